// ==== verilog/acrt_pkg.sv ====
// Constants shared by both ends of the converter readout link.
// Assumes both ends run their system clock at 25 MHz.
package acrt_pkg;

  // ****************************************************************
  // Clock and word format
  // ****************************************************************
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned CHAIN_LEN   = 1;
  localparam int unsigned FIFO_DEPTH  = 2;

  // ****************************************************************
  // Conversion timing, high and low supply, in ns
  // ****************************************************************
  localparam int unsigned CONV_MIN_HI_NS = 500;
  localparam int unsigned CONV_MAX_HI_NS = 2200;
  localparam int unsigned CONV_MIN_LO_NS = 700;
  localparam int unsigned CONV_MAX_LO_NS = 3200;
  // Chosen so that, with synchroniser delay, both supply ranges are met.
  localparam int unsigned CONV_NS        = 1600;
  localparam int unsigned SPACING_LO_NS  = 5000;
  localparam int unsigned ACQ_NS         = 1800;
  localparam int unsigned STROBE_HI_NS   = 10;
  localparam int unsigned CHAIN_SETUP_NS = 30;

  // ****************************************************************
  // Derived cycle counts
  // ****************************************************************
  localparam logic [7:0] CONV_CYC =
    8'(CONV_NS / CLK_NS);
  localparam logic [7:0] WAIT_CYC =
    8'((CONV_MAX_LO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SPACING_CYC =
    8'((SPACING_LO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACQ_CYC =
    8'((ACQ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC =
    8'((STROBE_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETUP_CYC =
    8'((CHAIN_SETUP_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // Readout counters
  // ****************************************************************
  localparam logic [4:0] BIT_LAST  = 5'h11;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [5:0] READ_BITS = 6'(RESULT_BITS * CHAIN_LEN);
  localparam logic [1:0] SCK_RISE  = 2'h1;
  localparam logic [1:0] SCK_FALL  = 2'h3;

endpackage : acrt_pkg

// ==== verilog/acrt_link_if.sv ====
// Pins between the converter and its host controller.
// Assumes the testbench instantiates it and joins both ends.
`timescale 1ns/1ps
interface acrt_link_if;
  logic convert_strobe;
  logic chain_input;
  logic link_sck;
  logic result_out_val;
  logic result_out_en;
  logic serial_result_out;

  // A released serial output reads high, as if held by a board pull-up.
  // The host only samples it while the converter drives it.
  assign serial_result_out = result_out_en ? result_out_val : 1'b1;

  modport dev (
    input  convert_strobe,
    input  chain_input,
    input  link_sck,
    output result_out_val,
    output result_out_en
  );

  modport host (
    output convert_strobe,
    output chain_input,
    output link_sck,
    input  serial_result_out
  );
endinterface : acrt_link_if

// ==== verilog/acrt_dev.sv ====
// Converter end: runs a conversion on its own clock, then shifts the result out.
// Assumes the host keeps the link clock still during conversion.
`timescale 1ns/1ps
module acrt_dev (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  acrt_link_if.dev         link,
  input  wire logic [15:0] sample_value,
  output logic             conv_active
);

  // ****************************************************************
  // Pin synchronisers and mode capture
  // ****************************************************************
  logic [1:0]  strobe_sync_q;
  logic [1:0]  chain_sync_q;
  logic [1:0]  sck_sync_q;
  logic        strobe_seen_q;
  logic        chain_mode_q;
  logic        chain_busy_q;
  logic        busy_sel_q;
  logic        converting_q;
  logic [7:0]  conv_cnt_q;
  logic [15:0] held_q;
  logic [15:0] result_q;
  logic        strobe_rise;
  logic        conv_end;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_sync_q <= 2'h0;
      chain_sync_q  <= 2'h0;
      sck_sync_q    <= 2'h0;
      strobe_seen_q <= 1'b0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[0], link.convert_strobe};
      chain_sync_q  <= {chain_sync_q[0], link.chain_input};
      sck_sync_q    <= {sck_sync_q[0], link.link_sck};
      strobe_seen_q <= strobe_sync_q[1];
    end
  end

  assign strobe_rise = strobe_sync_q[1] & ~strobe_seen_q;
  assign conv_end    = converting_q && (conv_cnt_q == acrt_pkg::CONV_CYC - 8'h01);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_mode_q <= 1'b0;
      chain_busy_q <= 1'b0;
    end else if (strobe_rise) begin
      chain_mode_q <= ~chain_sync_q[1];
      chain_busy_q <= sck_sync_q[1];
    end
  end

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      converting_q <= 1'b0;
      conv_cnt_q   <= 8'h00;
      held_q       <= 16'h0000;
    end else if (strobe_rise) begin
      converting_q <= 1'b1;
      conv_cnt_q   <= 8'h00;
      held_q       <= sample_value;
    end else if (conv_end) begin
      converting_q <= 1'b0;
    end else if (converting_q) begin
      conv_cnt_q   <= conv_cnt_q + 8'h01;
    end
  end

  // The result is loaded the same cycle the conversion ends.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q   <= 16'h0000;
      busy_sel_q <= 1'b0;
    end else if (conv_end) begin
      result_q   <= held_q;
      busy_sel_q <= ~(strobe_sync_q[1] & chain_sync_q[1]);
    end
  end

  assign conv_active = converting_q;

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  // The frame counters are cleared by the conversion itself, because the
  // link clock does not run between frames.
  logic        frame_clr;
  logic [4:0]  bit_cnt_q;
  logic [15:0] chain_sr_q;

  assign frame_clr = sys_rst | converting_q;

  always_ff @(negedge link.link_sck or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != acrt_pkg::BIT_LAST) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(negedge link.link_sck or posedge frame_clr) begin
    if (frame_clr) begin
      chain_sr_q <= 16'h0000;
    end else begin
      chain_sr_q <= {chain_sr_q[14:0], link.chain_input};
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  logic       busy_en;
  logic [4:0] pos;
  logic [4:0] last_pos;
  logic       enables_low;

  assign busy_en     = chain_mode_q ? chain_busy_q : busy_sel_q;
  assign pos         = bit_cnt_q - {4'h0, busy_en};
  assign last_pos    = acrt_pkg::WORD_BITS + {4'h0, busy_en};
  assign enables_low = ~(link.convert_strobe & link.chain_input);

  always_comb begin
    if (converting_q) begin
      link.result_out_val = 1'b0;
    end else if (busy_en && (bit_cnt_q == 5'h00)) begin
      link.result_out_val = chain_mode_q ? link.chain_input : 1'b1;
    end else if (pos < acrt_pkg::WORD_BITS) begin
      link.result_out_val = result_q[4'(5'h0F - pos)];
    end else begin
      link.result_out_val = chain_sr_q[15];
    end
  end

  // In select mode the pin is driven only while an enable is low and
  // the word has not yet run out.
  always_comb begin
    if (chain_mode_q) begin
      link.result_out_en = 1'b1;
    end else begin
      link.result_out_en = enables_low &&
                           (converting_q || (bit_cnt_q < last_pos));
    end
  end

endmodule : acrt_dev

// ==== verilog/acrt_host.sv ====
// Host end: starts conversions, makes the link clock and reads results.
// Assumes one converter on the link and a user that drains the word buffer.
//
// How it works
// - Conversion ends 0.5 to 2.2 us, high supply.
// - Conversion ends 0.7 to 3.2 us, low supply.
// - Strobes spaced 4 or 5 us, 1.8 us acquisition.
// - Strobe stays high at least 10 ns.
// - Select mode link clock period at least 15/25 ns.
// - Chain mode link clock period at least 17-40 ns.
// - Output changes after each falling link clock edge.
// - Enable low puts the top result bit out first.
// - Output floats after enable high or last edge.
// - Chain input settles 15/30 ns before strobe rises.
// - Chain mode: link clock steady around strobe rise.
// - Chain input held 3/4 ns around falling edges.
// - Chain busy: output follows chain input high.
// - Chain input low at strobe rise selects chain.
// - Chain input reaches output 16 clocks later.
// - Enable low at completion turns busy indicator on.
// - Result readable right after its own conversion.
`timescale 1ns/1ps
module acrt_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start_valid,
  input  wire logic        start_chain,
  output logic             start_ready,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [15:0]      word_data,
  acrt_link_if.host        link
);

  // ****************************************************************
  // State machine
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h3,
    ST_WAIT   = 3'h2,
    ST_SHIFT  = 3'h6,
    ST_ACQ    = 3'h7
  } acrt_state_t;

  acrt_state_t state_q;
  logic        chain_q;
  logic        strobe_q;
  logic        chain_in_q;
  logic        sck_q;
  logic [7:0]  tmr_q;
  logic [7:0]  spacing_q;
  logic [1:0]  ph_q;
  logic [5:0]  bits_q;
  logic [15:0] shreg_q;
  logic [1:0]  rx_sync_q;
  logic        fifo_room;
  logic        spaced;
  logic        sample_now;
  logic        push;
  logic        pop;
  logic [15:0] push_word;

  assign spaced      = (spacing_q == acrt_pkg::SPACING_CYC);
  assign start_ready = (state_q == ST_IDLE) && spaced && fifo_room;
  assign sample_now  = (state_q == ST_SHIFT) && (ph_q == acrt_pkg::SCK_FALL);
  assign push_word   = {shreg_q[14:0], rx_sync_q[1]};
  assign push        = sample_now && (bits_q[3:0] == 4'hF);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      tmr_q   <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          tmr_q <= 8'h00;
          if (start_valid && start_ready) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tmr_q == acrt_pkg::SETUP_CYC - 8'h01) begin
            state_q <= ST_STROBE;
            tmr_q   <= 8'h00;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        ST_STROBE: begin
          if (tmr_q == acrt_pkg::STROBE_CYC - 8'h01) begin
            state_q <= ST_WAIT;
            tmr_q   <= 8'h00;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        ST_WAIT: begin
          if (tmr_q == acrt_pkg::WAIT_CYC - 8'h01) begin
            state_q <= ST_SHIFT;
            tmr_q   <= 8'h00;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        ST_SHIFT: begin
          if (sample_now && (bits_q == acrt_pkg::READ_BITS - 6'h01)) begin
            state_q <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (tmr_q == acrt_pkg::ACQ_CYC - 8'h01) begin
            state_q <= ST_IDLE;
            tmr_q   <= 8'h00;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          tmr_q   <= 8'h00;
        end
      endcase
    end
  end

  // Spacing counts from each strobe rise and saturates once the least
  // time between conversions has passed.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spacing_q <= acrt_pkg::SPACING_CYC;
    end else if ((state_q == ST_SETUP) && (tmr_q == acrt_pkg::SETUP_CYC - 8'h01)) begin
      spacing_q <= 8'h00;
    end else if (!spaced) begin
      spacing_q <= spacing_q + 8'h01;
    end
  end

  // ****************************************************************
  // Strobe and chain input pins
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_q    <= 1'b0;
      chain_in_q <= 1'b1;
    end else if ((state_q == ST_IDLE) && start_valid && start_ready) begin
      chain_q    <= start_chain;
      chain_in_q <= ~start_chain;
    end else if (state_q == ST_ACQ) begin
      chain_in_q <= 1'b1;
    end
  end

  // Chain mode reads with the strobe high; select mode drops it to
  // enable the converter's output.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_q <= 1'b0;
    end else if ((state_q == ST_SETUP) && (tmr_q == acrt_pkg::SETUP_CYC - 8'h01)) begin
      strobe_q <= 1'b1;
    end else if ((state_q == ST_WAIT) && (tmr_q == acrt_pkg::WAIT_CYC - 8'h01)) begin
      strobe_q <= chain_q;
    end else if (state_q == ST_ACQ) begin
      strobe_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Link clock divider and receive shifter
  // ****************************************************************
  // Four system cycles per link clock give 160 ns, and leave two cycles
  // for the returning bit to clear its synchroniser before sampling.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q  <= 2'h0;
      sck_q <= 1'b0;
    end else if (state_q == ST_SHIFT) begin
      ph_q  <= ph_q + 2'h1;
      sck_q <= (ph_q == acrt_pkg::SCK_RISE) || (ph_q == 2'h2);
    end else begin
      ph_q  <= 2'h0;
      sck_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sync_q <= 2'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], link.serial_result_out};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits_q  <= 6'h00;
      shreg_q <= 16'h0000;
    end else if (state_q != ST_SHIFT) begin
      bits_q  <= 6'h00;
    end else if (sample_now) begin
      bits_q  <= bits_q + 6'h01;
      shreg_q <= push_word;
    end
  end

  assign link.convert_strobe = strobe_q;
  assign link.chain_input    = chain_in_q;
  assign link.link_sck       = sck_q;

  // ****************************************************************
  // Two-entry word buffer
  // ****************************************************************
  logic [15:0] mem_q [acrt_pkg::FIFO_DEPTH];
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [1:0]  cnt_q;

  assign word_valid = (cnt_q != 2'h0);
  assign pop        = word_valid && word_ready;
  assign fifo_room  = (cnt_q == 2'h0);
  assign word_data  = mem_q[rd_ptr_q];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_q[0] <= 16'h0000;
      mem_q[1] <= 16'h0000;
    end else if (push) begin
      mem_q[wr_ptr_q] <= push_word;
    end
  end

endmodule : acrt_host

// ==== sim/acrt_link_props.sv ====
// Checker for the link between converter and host.
// Assumes both ends share clk and are instantiated beside this checker.
`timescale 1ns/1ps
module acrt_link_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic convert_strobe,
  input wire logic chain_input,
  input wire logic link_sck,
  input wire logic result_out_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [7:0] since_q;
  logic [4:0] fall_q;
  logic       chain_q;

  // Saturates so that the first strobe after reset passes the spacing check.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q <= 8'hFF;
    end else if ($rose(convert_strobe)) begin
      since_q <= 8'h01;
    end else if (since_q != 8'hFF) begin
      since_q <= since_q + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_q  <= 5'h00;
      chain_q <= 1'b0;
    end else if ($rose(convert_strobe)) begin
      fall_q  <= 5'h00;
      chain_q <= !chain_input;
    end else if ($fell(link_sck) && fall_q != 5'h1F) begin
      fall_q <= fall_q + 5'h01;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  strobe_width_a: assert property (
    $rose(convert_strobe) |=> convert_strobe) else $error("strobe pulse too short");
  strobe_spacing_a: assert property (
    $rose(convert_strobe) |-> since_q >= 8'h7D) else $error("strobes too close");
  read_wait_a: assert property (
    $rose(link_sck) |-> since_q >= 8'h50) else $error("readout before conversion end");
  sck_shape_a: assert property (
    $rose(link_sck) |-> link_sck [*2] ##1 !link_sck) else $error("link clock high time");
  sck_still_a: assert property (
    $rose(convert_strobe) |-> $stable(link_sck) ##1 $stable(link_sck))
    else $error("link clock moved at strobe");
  mode_setup_a: assert property (
    $rose(convert_strobe) |-> $stable(chain_input)) else $error("chain input not settled");
  chain_hold_a: assert property (
    $fell(link_sck) |-> $stable(chain_input)) else $error("chain input moved at fall");
  // The converter sees the strobe through a two-stage synchroniser, so
  // its mode takes effect a few cycles after the rising edge.
  chain_drive_a: assert property (
    chain_q && convert_strobe && since_q >= 8'h04 |-> result_out_en)
    else $error("chain output not driven");
  select_release_a: assert property (
    $changed(fall_q) && fall_q == 5'h10 && !chain_q |-> ##[0:4] !result_out_en)
    else $error("output not released after last fall");
  fall_count_a: assert property (
    $rose(convert_strobe) |-> fall_q inside {5'h00, 5'h10}) else $error("wrong fall count");
endmodule : acrt_link_props

// ==== sim/adc_conversion_readout_timing_test.sv ====
// Testbench joining host and converter ends through the link interface.
// Assumes one 25 MHz clock for both ends.
`timescale 1ns/1ps
module adc_conversion_readout_timing_test;
  logic        clk;
  logic        sys_rst;
  logic        start_valid;
  logic        start_chain;
  logic        start_ready;
  logic        word_valid;
  logic        word_ready;
  logic [15:0] word_data;
  logic [15:0] sample_value;
  logic        conv_active;
  logic [15:0] wire_word;
  int          mismatches;
  int          n_compared;
  int          cyc;
  int          take_cyc;

  acrt_link_if link ();
  acrt_dev i_acrt_dev (.clk(clk), .sys_rst(sys_rst), .link(link),
    .sample_value(sample_value), .conv_active(conv_active));
  acrt_host i_acrt_host (.clk(clk), .sys_rst(sys_rst), .start_valid(start_valid),
    .start_chain(start_chain), .start_ready(start_ready), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .link(link));
  acrt_link_props i_acrt_link_props (.clk(clk), .sys_rst(sys_rst),
    .convert_strobe(link.convert_strobe), .chain_input(link.chain_input),
    .link_sck(link.link_sck), .result_out_en(link.result_out_en));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // The host samples before each fall, so the wire is read at the fall too.
  always @(negedge link.link_sck) wire_word = {wire_word[14:0], link.serial_result_out};

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic start(input logic chain, input logic [15:0] value);
    int n;
    n = 0;
    sample_value <= value;
    start_chain  <= chain;
    start_valid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (start_ready !== 1'b1 && n < 400);
    if (start_ready !== 1'b1) mismatches++;
    take_cyc = cyc;
    start_valid <= 1'b0;
  endtask : start

  task automatic convert(input logic chain, input logic [15:0] value);
    int n;
    int act;
    n = 0;
    act = 0;
    start(chain, value);
    while (word_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
      if (conv_active === 1'b1) act++;
    end
    if (word_valid !== 1'b1) mismatches++;
    check(word_data, value);
    check(wire_word, value);
    check(16'(act), 16'(acrt_pkg::CONV_CYC));
    if (chain === 1'b0) check({15'h0, link.result_out_en}, 16'h0);
    word_ready <= 1'b1;
    @(posedge clk);
    word_ready <= 1'b0;
    @(posedge clk);
    check({15'h0, word_valid}, 16'h0);
  endtask : convert

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_modes();
    convert(1'b0, 16'hA5C3);
    convert(1'b1, 16'h8001);
    convert(1'b1, 16'h7FFE);
  endtask : t_modes

  task automatic t_spacing();
    int first;
    convert(1'b0, 16'h0000);
    first = take_cyc;
    convert(1'b0, 16'hFFFF);
    check(16'(take_cyc - first >= int'(acrt_pkg::SPACING_CYC)), 16'h1);
  endtask : t_spacing

  // A buffer holding one unread word must hold off a new request without losing the word.
  task automatic t_stall();
    int n;
    start(1'b0, 16'h3C5A);
    n = 0;
    while (word_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (word_valid !== 1'b1) mismatches++;
    start_valid <= 1'b1;
    repeat (250) @(posedge clk);
    check({15'h0, start_ready}, 16'h0);
    check(word_data, 16'h3C5A);
    start_valid <= 1'b0;
    word_ready  <= 1'b1;
    @(posedge clk);
    word_ready <= 1'b0;
    convert(1'b0, 16'h5AA5);
  endtask : t_stall

  task automatic t_reset_mid();
    start(1'b0, 16'hDEAD);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check({15'h0, word_valid}, 16'h0);
    check({15'h0, conv_active}, 16'h0);
    convert(1'b0, 16'h1234);
  endtask : t_reset_mid

  initial begin
    sys_rst      = 1'b1;
    start_valid  = 1'b0;
    start_chain  = 1'b0;
    word_ready   = 1'b0;
    sample_value = 16'h0000;
    wire_word    = 16'h0000;
    mismatches   = 0;
    n_compared   = 0;
    cyc          = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_modes();
    t_spacing();
    t_stall();
    t_reset_mid();
    tally_and_finish();
  end

  // Nine conversions at about 200 cycles each fit well inside this span.
  initial begin
    #(40 * 20000);
    mismatches++;
    tally_and_finish();
  end
endmodule : adc_conversion_readout_timing_test
